// *** dv/coproc_register_transfer_test.sv ***
// self-checking bench for both ends of the register transfer link
`timescale 1ns/1ps
module coproc_register_transfer_test import crt_pkg::*;;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic [4:0] adr_i = 5'h00;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0;
   logic [31:0] dat_o, rd, host_rdata_o;
   logic ack_o, irq_o, op_o;
   logic present_i = 1'b1;
   logic host_we_i = 1'b0;
   logic [3:0] host_idx_i = 4'h0;
   logic [31:0] host_wdata_i = 32'h0;
   logic [2:0] op_code_o, op_aux_o;
   logic [3:0] op_crm_o;
   int err_total = 0;
   int cmp_count = 0;
   int op_seen = 0;

   // two ends joined by the link
   crt_link_if link ();
   crt_proc_end i_crt_proc_end (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
      .irq_o, .link(link));
   crt_cop_end #(.CP_NUM(4'h1)) i_crt_cop_end (.clk_i, .rst_i, .link(link), .present_i, .host_we_i, .host_idx_i,
      .host_wdata_i, .host_rdata_o, .op_o, .op_code_o, .op_aux_o, .op_crm_o);
   crt_link_asserts #(.CP_NUM(4'h1)) i_crt_link_asserts (.clk_i, .rst_i, .offer(link.offer), .instr(link.instr),
      .coproc_absent_line(link.coproc_absent_line), .dev_oe_n(link.dev_oe_n), .cop_oe_n(link.cop_oe_n));

   // 100 MHz clock
   initial begin
      forever #5 clk_i = ~clk_i;
   end

   // count one-cycle transfer-complete pulses of the coprocessor end
   always @(posedge clk_i) begin
      if (op_o === 1'b1) begin
         op_seen <= op_seen + 1;
      end
   end

   task automatic final_report();
      $display("checks %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // one classic wishbone cycle, then one idle cycle
   task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      sel_i <= 4'hF;
      dat_i <= d;
      for (n = 0; n < 20; n++) begin
         @(posedge clk_i);
         if (ack_o === 1'b1) break;
      end
      rd = dat_o;
      if (n == 20) begin
         chk("ack", 32'h1, 32'h0);
         final_report();
      end
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask

   // start an order and poll busy until it clears
   task automatic run(input logic [31:0] ins, input logic [31:0] exp_st);
      wb(1'b1, OFS_INSTR, ins);
      for (int n = 0; n < 20; n++) begin
         wb(1'b0, OFS_STATUS, 32'h0);
         if (rd[0] === 1'b0) break;
      end
      chk("status", exp_st, rd);
   endtask

   task automatic hw(input logic [3:0] i, input logic [31:0] d);
      host_we_i <= 1'b1;
      host_idx_i <= i;
      host_wdata_i <= d;
      @(posedge clk_i);
      host_we_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic hr(input logic [3:0] i, input logic [31:0] exp);
      host_idx_i <= i;
      @(posedge clk_i);
      #1 chk("cop reg", exp, host_rdata_o);
      @(posedge clk_i);
   endtask

   function automatic logic [31:0] mk(input logic [3:0] c, input logic ld, input logic [3:0] coproc_primary_reg_field, rdx, cpn);
      return {c, CLASS_REG_XFER, 3'h5, ld, coproc_primary_reg_field, rdx, cpn, 3'h2, 1'b1, 4'h9};
   endfunction

   task automatic t_basic();
      wb(1'b0, OFS_PSR, 32'h0);
      chk("psr", PSR_RESET, rd);
      wb(1'b0, OFS_IRQ_MASK, 32'h0);
      chk("mask", {29'h0, IRQ_MASK_RESET}, rd);
      wb(1'b1, 5'h1C, 32'hFFFF_FFFF);
      wb(1'b0, 5'h1C, 32'h0);
      chk("unmapped", 32'h0, rd);
      wb(1'b1, OFS_WDATA, 32'hA5A5_1234);
      run(mk(4'hE, 1'b0, 4'hF, 4'h1, 4'h1), 32'h2);
      hr(4'hF, 32'hA5A5_1234);
      chk("op pulse", 32'h1, op_seen);
      chk("opc aux crm", 32'h0000_0A89, {op_code_o, op_aux_o, 2'h0, op_crm_o});
      hw(4'h7, 32'h1357_9BDF);
      run(mk(4'hE, 1'b1, 4'h7, 4'h2, 4'h1), 32'h2);
      wb(1'b0, OFS_RDATA, 32'h0);
      chk("rdata", 32'h1357_9BDF, rd);
      $display("test basic done");
   endtask

   task automatic t_r15();
      wb(1'b1, OFS_PSR, 32'h0FFF_FFFC);
      hw(4'h3, 32'hA0FF_FF00);
      run(mk(4'hE, 1'b1, 4'h3, PC_REG_IDX, 4'h1), 32'h2);
      wb(1'b0, OFS_PSR, 32'h0);
      chk("psr flags", 32'hAFFF_FFFC, rd);
      wb(1'b0, OFS_RDATA, 32'h0);
      chk("rdata kept", 32'h1357_9BDF, rd);
      run(mk(4'hE, 1'b0, 4'h4, PC_REG_IDX, 4'h1), 32'h2);
      hr(4'h4, 32'hAFFF_FFFC);
      $display("test r15 done");
   endtask

   // flags are N=1 Z=0 C=1 V=0 here
   task automatic t_cond();
      logic [63:0] cl = 64'hFEDC_BA98_7654_3210;
      logic [15:0] ok = 16'h6996;
      for (int i = 0; i < 16; i++) begin
         run(mk(cl[i*4+:4], 1'b0, 4'h5, 4'h1, 4'h1), ok[i] ? 32'h2 : 32'h8);
      end
      $display("test cond done");
   endtask

   task automatic t_trap();
      run(mk(4'hE, 1'b0, 4'h5, 4'h1, 4'h2), 32'h4);
      present_i <= 1'b0;
      run(mk(4'hE, 1'b0, 4'h5, 4'h1, 4'h1), 32'h4);
      present_i <= 1'b1;
      run({4'hE, CLASS_UNDEF, 20'h0_0110, 1'b1, 4'h0}, 32'h4);
      run({4'h0, CLASS_UNDEF, 20'h0_0110, 1'b1, 4'h0}, 32'h8);
      chk("op pulses", 32'hC, op_seen);
      $display("test trap done");
   endtask

   task automatic t_irq();
      wb(1'b0, OFS_IRQ_STAT, 32'h0);
      chk("irq stat", 32'h7, rd);
      chk("irq masked", 32'h0, {31'h0, irq_o});
      wb(1'b1, OFS_IRQ_MASK, 32'h2);
      chk("irq on", 32'h1, {31'h0, irq_o});
      wb(1'b1, OFS_IRQ_STAT, 32'h2);
      chk("irq cleared", 32'h0, {31'h0, irq_o});
      wb(1'b0, OFS_IRQ_STAT, 32'h0);
      chk("irq stat w1c", 32'h5, rd);
      $display("test irq done");
   endtask

   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_basic();
      t_r15();
      t_cond();
      t_trap();
      t_irq();
      final_report();
   end
endmodule // coproc_register_transfer_test

// *** dv/crt_link_asserts.sv ***
// concurrent checks on the link between the two ends
`timescale 1ns/1ps
module crt_link_asserts import crt_pkg::*; #(
   parameter logic [3:0] CP_NUM = 4'h1
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // link
   input wire logic offer,
   input wire logic [31:0] instr,
   input wire logic coproc_absent_line,
   input wire logic dev_oe_n,
   input wire logic cop_oe_n
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // offers, answers and data cycles
   a_nv_never_offered: assert property (offer |-> instr[31:28] != 4'hF) else $error("never cond offered");
   a_other_cp_absent: assert property (offer && instr[11:8] != CP_NUM |=> coproc_absent_line)
      else $error("foreign number accepted");
   a_undef_refused: assert property (offer && instr[27:25] == CLASS_UNDEF && instr[MARK_BIT]
      |=> coproc_absent_line) else $error("undefined class accepted");
   a_accept_after_offer: assert property ($fell(coproc_absent_line) |-> $past(offer))
      else $error("accept without offer");
   a_refused_no_data: assert property (offer ##1 coproc_absent_line |=> dev_oe_n && cop_oe_n)
      else $error("data after refusal");
   a_dev_drives_store: assert property ($fell(dev_oe_n) |-> !instr[LOAD_BIT] && !$past(coproc_absent_line))
      else $error("processor drives on load");
   a_cop_drives_load: assert property ($fell(cop_oe_n) |-> instr[LOAD_BIT] && !$past(coproc_absent_line))
      else $error("coprocessor drives on store");
   a_data_one_cycle: assert property (offer ##1 !coproc_absent_line |=> (dev_oe_n != cop_oe_n)
      ##1 (dev_oe_n && cop_oe_n)) else $error("data cycle wrong");

   // main scenarios
   c_accepted: cover property (offer ##1 !coproc_absent_line);
   c_refused: cover property (offer ##1 coproc_absent_line);
   c_load: cover property ($fell(cop_oe_n));
endmodule // crt_link_asserts

// *** src/crt_cop_end.sv ***
// coprocessor end: answers register transfers addressed to its number
`timescale 1ns/1ps
module crt_cop_end import crt_pkg::*; #(
   parameter logic [3:0] CP_NUM = 4'h1
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // link
   crt_link_if.cop link,
   // user side
   input wire logic present_i,
   input wire logic host_we_i,
   input wire logic [3:0] host_idx_i,
   input wire logic [31:0] host_wdata_i,
   output logic [31:0] host_rdata_o,
   output logic op_o,
   output logic [2:0] op_code_o,
   output logic [2:0] op_aux_o,
   output logic [3:0] op_crm_o
);
   typedef struct packed {
      crt_cstate_e st;
      logic [31:0] instr;
      logic absent;
      logic [31:0] dout;
      logic oe_n;
      logic op;
      logic [15:0][31:0] regs;
   } crt_cop_s;

   crt_cop_s s_q, s_d;
   logic mine;
   logic [3:0] coproc_primary_reg_field;

   // accept only own-numbered register transfers while present
   assign mine = link.offer && present_i && (link.instr[27:24] == CLASS_REG_XFER)
      && link.instr[MARK_BIT] && (link.instr[CPNUM_LSB +: 4] == CP_NUM);
   assign coproc_primary_reg_field = s_q.instr[CRN_LSB +: 4];

   // next state
   always_comb begin
      s_d = s_q;
      s_d.op = 1'b0;
      if (host_we_i) begin
         s_d.regs[host_idx_i] = host_wdata_i;
      end
      unique case (s_q.st)
         CS_IDLE: begin
            s_d.absent = 1'b1; // refuse by default
            if (mine) begin
               s_d.instr = link.instr;
               s_d.absent = 1'b0;
               s_d.st = CS_ANS;
            end
         end
         CS_ANS: begin
            s_d.absent = 1'b1;
            s_d.st = CS_XFER;
            if (s_q.instr[LOAD_BIT]) begin
               s_d.dout = s_q.regs[coproc_primary_reg_field]; // word to processor
               s_d.oe_n = 1'b0;
            end
         end
         CS_XFER: begin
            if (!s_q.instr[LOAD_BIT]) begin
               s_d.regs[coproc_primary_reg_field] = link.dat; // word from processor
            end
            s_d.oe_n = 1'b1;
            s_d.op = 1'b1;
            s_d.st = CS_IDLE;
         end
         default: begin
            s_d.st = CS_IDLE; // unused code returns to idle
         end
      endcase
   end

   // state register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '{st: CS_IDLE, absent: 1'b1, oe_n: 1'b1, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   assign link.coproc_absent_line = s_q.absent;
   assign link.cop_dat = s_q.dout;
   assign link.cop_oe_n = s_q.oe_n;
   assign host_rdata_o = s_q.regs[host_idx_i];
   assign op_o = s_q.op;
   assign op_code_o = s_q.instr[OPC_LSB +: 3];
   assign op_aux_o = s_q.instr[AUX_LSB +: 3];
   assign op_crm_o = s_q.instr[CRM_LSB +: 4];
endmodule // crt_cop_end

// *** src/crt_link_if.sv ***
// link between the processor end and one coprocessor end
`timescale 1ns/1ps
interface crt_link_if;
   logic offer;
   logic [31:0] instr;
   logic coproc_absent_line;
   logic [31:0] dev_dat;
   logic dev_oe_n;
   logic [31:0] cop_dat;
   logic cop_oe_n;
   logic [31:0] dat;

   // shared data bus level, worked out from the two enables
   assign dat = !dev_oe_n ? dev_dat : (!cop_oe_n ? cop_dat : 32'h0000_0000);

   modport dev (
      output offer,
      output instr,
      input coproc_absent_line,
      output dev_dat,
      output dev_oe_n,
      input dat
   );
   modport cop (
      input offer,
      input instr,
      output coproc_absent_line,
      output cop_dat,
      output cop_oe_n,
      input dat
   );
endinterface

// *** src/crt_pkg.sv ***
// shared constants and types for the coprocessor register transfer link
package crt_pkg;
   // instruction field positions
   localparam int unsigned COND_LSB = 28;
   localparam int unsigned LOAD_BIT = 20;
   localparam int unsigned RD_LSB = 12;
   localparam int unsigned CPNUM_LSB = 8;
   localparam int unsigned CRN_LSB = 16;
   localparam int unsigned CRM_LSB = 0;
   localparam int unsigned OPC_LSB = 21;
   localparam int unsigned AUX_LSB = 5;
   localparam int unsigned MARK_BIT = 4;
   localparam int unsigned FLAG_LSB = 28;
   // class codes: bits 27:24 of a register transfer, bits 27:25 of the undefined class
   localparam logic [3:0] CLASS_REG_XFER = 4'hE;
   localparam logic [2:0] CLASS_UNDEF = 3'h3;
   localparam logic [3:0] PC_REG_IDX = 4'hF;
   // register byte offsets of the processor end
   localparam logic [4:0] OFS_INSTR = 5'h00;
   localparam logic [4:0] OFS_WDATA = 5'h04;
   localparam logic [4:0] OFS_PSR = 5'h08;
   localparam logic [4:0] OFS_RDATA = 5'h0C;
   localparam logic [4:0] OFS_STATUS = 5'h10;
   localparam logic [4:0] OFS_IRQ_STAT = 5'h14;
   localparam logic [4:0] OFS_IRQ_MASK = 5'h18;
   // reset values
   localparam logic [31:0] PSR_RESET = 32'h0000_0000;
   localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
   // event bit positions in interrupt status and mask; status holds them one bit higher, above busy
   localparam int unsigned EV_DONE = 0;
   localparam int unsigned EV_TRAP = 1;
   localparam int unsigned EV_SKIP = 2;
   // processor end sequencer
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_OFFER,
      ST_WAIT,
      ST_XFER
   } crt_pstate_e;
   // coprocessor end sequencer
   typedef enum logic [1:0] {
      CS_IDLE,
      CS_ANS,
      CS_XFER
   } crt_cstate_e;
endpackage

// *** src/crt_proc_end.sv ***
// processor end: issues coprocessor register transfers ordered over wishbone
// Behaviour
// - run transfer only if condition passes
// - coprocessor number selects the responding coprocessor
// - opcode and register fields passed through uninterpreted
// - coprocessor decodes opcode, aux and registers
// - coprocessor register specifiers are four bits
// - to R15 loads bits 31-28 into NZCV
// - to R15 discards rest, PC unchanged
// - from R15 sends PC and flags word
// - passing undefined class takes the trap
// - coprocessors refuse undefined class, absent high
`timescale 1ns/1ps
module crt_proc_end import crt_pkg::*; (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [4:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // interrupt
   output logic irq_o,
   // link
   crt_link_if.dev link
);
   // all state of the processor end in one record
   typedef struct packed {
      crt_pstate_e st;
      logic [31:0] instr;
      logic [31:0] wdata;
      logic [31:0] psr;
      logic [31:0] rdata;
      logic [2:0] last;
      logic [2:0] irq_stat;
      logic [2:0] irq_mask;
      logic ack;
      logic [31:0] rd_dat;
      logic offer;
      logic [31:0] dout;
      logic oe_n;
   } crt_proc_s;

   // registered state and its next value
   crt_proc_s s_q, s_d;
   logic req;
   logic [31:0] wmask;
   logic [2:0] ev;
   logic cond_ok;
   logic is_xfer;
   logic is_undef;

   // condition test against the flags
   function automatic logic cond_pass(input logic [3:0] c, input logic [3:0] f);
      logic n, z, cy, v;
      {n, z, cy, v} = f;
      unique case (c)
         4'h0: cond_pass = z;
         4'h1: cond_pass = !z;
         4'h2: cond_pass = cy;
         4'h3: cond_pass = !cy;
         4'h4: cond_pass = n;
         4'h5: cond_pass = !n;
         4'h6: cond_pass = v;
         4'h7: cond_pass = !v;
         4'h8: cond_pass = cy && !z;
         4'h9: cond_pass = !cy || z;
         4'hA: cond_pass = (n == v);
         4'hB: cond_pass = (n != v);
         4'hC: cond_pass = !z && (n == v);
         4'hD: cond_pass = z || (n != v);
         4'hE: cond_pass = 1'b1;
         4'hF: cond_pass = 1'b0;
      endcase
   endfunction

   // decode of the pending order
   assign req = cyc_i && stb_i && !s_q.ack;
   assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
   assign cond_ok = cond_pass(s_q.instr[COND_LSB +: 4], s_q.psr[FLAG_LSB +: 4]);
   // class of the held order word
   assign is_xfer = (s_q.instr[27:24] == CLASS_REG_XFER) && s_q.instr[MARK_BIT];
   assign is_undef = (s_q.instr[27:25] == CLASS_UNDEF) && s_q.instr[MARK_BIT];

   // next state
   always_comb begin
      s_d = s_q;
      ev = 3'h0;
      s_d.ack = req;
      s_d.offer = 1'b0;
      // register reads
      if (req) begin
         unique case (adr_i)
            OFS_INSTR: s_d.rd_dat = s_q.instr;
            OFS_WDATA: s_d.rd_dat = s_q.wdata;
            OFS_PSR: s_d.rd_dat = s_q.psr;
            OFS_RDATA: s_d.rd_dat = s_q.rdata;
            OFS_STATUS: s_d.rd_dat = {28'h0, s_q.last, s_q.st != ST_IDLE};
            OFS_IRQ_STAT: s_d.rd_dat = {29'h0, s_q.irq_stat};
            OFS_IRQ_MASK: s_d.rd_dat = {29'h0, s_q.irq_mask};
            default: s_d.rd_dat = 32'h0000_0000;
         endcase
      end
      // register writes; order register ignored while busy
      if (req && we_i) begin
         unique case (adr_i)
            OFS_INSTR: begin
               if (s_q.st == ST_IDLE) begin
                  s_d.instr = (s_q.instr & ~wmask) | (dat_i & wmask);
                  s_d.st = ST_OFFER;
               end
            end
            OFS_WDATA: s_d.wdata = (s_q.wdata & ~wmask) | (dat_i & wmask);
            OFS_PSR: s_d.psr = (s_q.psr & ~wmask) | (dat_i & wmask);
            OFS_IRQ_MASK: begin
               if (sel_i[0]) begin
                  s_d.irq_mask = dat_i[2:0];
               end
            end
            default: begin
            end
         endcase
      end
      // sequencer
      unique case (s_q.st)
         ST_IDLE: begin
            // waits for a write to the order register
         end
         ST_OFFER: begin
            // condition and class decide between skip and offer
            if (!cond_ok) begin
               ev[EV_SKIP] = 1'b1; // failed condition is a no-op
               s_d.st = ST_IDLE;
            end else if (is_xfer || is_undef) begin
               s_d.offer = 1'b1; // whole word offered, fields untouched
               s_d.st = ST_WAIT;
            end else begin
               ev[EV_SKIP] = 1'b1; // other classes not handled here
               s_d.st = ST_IDLE;
            end
         end
         ST_WAIT: begin
            if (s_q.offer) begin
               // offer cycle itself: the answer is registered one cycle later
            end else if (is_undef || link.coproc_absent_line) begin
               ev[EV_TRAP] = 1'b1;
               s_d.st = ST_IDLE;
            end else begin
               // accepted: the word moves in the next cycle
               s_d.st = ST_XFER;
               if (!s_q.instr[LOAD_BIT]) begin
                  // pc and flags word when source is r15
                  s_d.dout = (s_q.instr[RD_LSB +: 4] == PC_REG_IDX) ? s_q.psr : s_q.wdata;
                  s_d.oe_n = 1'b0;
               end
            end
         end
         ST_XFER: begin
            // data cycle ends, incoming word taken here
            s_d.oe_n = 1'b1;
            ev[EV_DONE] = 1'b1;
            s_d.st = ST_IDLE;
            if (s_q.instr[LOAD_BIT]) begin
               if (s_q.instr[RD_LSB +: 4] == PC_REG_IDX) begin
                  s_d.psr[FLAG_LSB +: 4] = link.dat[31:28];
               end else begin
                  s_d.rdata = link.dat;
               end
            end
         end
      endcase
      // outcome and sticky events, a new event wins over its clear
      if (ev != 3'h0) begin
         s_d.last = ev;
      end
      // write one to clear, then new events set
      s_d.irq_stat = s_q.irq_stat;
      if (req && we_i && (adr_i == OFS_IRQ_STAT) && sel_i[0]) begin
         s_d.irq_stat = s_q.irq_stat & ~dat_i[2:0];
      end
      s_d.irq_stat = s_d.irq_stat | ev;
   end

   // state register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '{st: ST_IDLE, psr: PSR_RESET, irq_mask: IRQ_MASK_RESET, oe_n: 1'b1, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   // outputs
   assign dat_o = s_q.rd_dat;
   assign ack_o = s_q.ack;
   assign irq_o = |(s_q.irq_stat & s_q.irq_mask);
   // link side
   assign link.offer = s_q.offer;
   assign link.instr = s_q.instr;
   assign link.dev_dat = s_q.dout;
   assign link.dev_oe_n = s_q.oe_n;
endmodule // crt_proc_end
